// ---- rtl/sac_regs.vh ----
`ifndef SAC_REGS_VH
`define SAC_REGS_VH
// Aperture-delay field widths
`define SAC_COARSE_W 8
`define SAC_FINE_W 8
`define SAC_RESULT_W 17
// Result field layout: {invert, coarse, fine}
`define SAC_RES_INV_BIT 16
`define SAC_RES_COARSE_HI 15
`define SAC_RES_COARSE_LO 8
`define SAC_RES_FINE_HI 7
`define SAC_RES_FINE_LO 0
// Coarse search span and settling per step
`define SAC_COARSE_MAX 8'hFF
`define SAC_SETTLE_CYCLES 8'h08
// Longest wait for a reference edge before a step counts as a miss
`define SAC_REF_WAIT_CYCLES 8'hFF
`define SAC_CFG_W 8
`endif

// ---- rtl/sac_align_cal.v ----
`timescale 1ns/1ps
// Operation
// - Enable rise steps delays until edges align
// - Completion flag raised when search finishes
// - Chosen delay readable as result field
// - Calibrated delay applied until enable is dropped (or reset)
// - After disable, manual delay value is honoured
// - Stored result written manually, applied without search
// - Try both polarities, pick smallest coarse
`include "sac_regs.vh"

module sac_align_cal (
   sys_clk,
   reset_n,
   sysref_in,
   clk_fall_phase_in,
   align_cal_enable,
   align_cal_config,
   manual_clock_invert,
   manual_delay_coarse,
   manual_delay_fine,
   align_cal_complete,
   align_cal_busy,
   align_cal_result,
   aperture_clock_invert,
   aperture_delay_coarse,
   aperture_delay_fine
);
   input wire sys_clk;
   input wire reset_n;
   input wire sysref_in;
   input wire clk_fall_phase_in;
   input wire align_cal_enable;
   input wire [`SAC_CFG_W-1:0] align_cal_config;
   input wire manual_clock_invert;
   input wire [`SAC_COARSE_W-1:0] manual_delay_coarse;
   input wire [`SAC_FINE_W-1:0] manual_delay_fine;
   output reg align_cal_complete;
   output wire align_cal_busy;
   output reg [`SAC_RESULT_W-1:0] align_cal_result;
   output reg aperture_clock_invert;
   output reg [`SAC_COARSE_W-1:0] aperture_delay_coarse;
   output reg [`SAC_FINE_W-1:0] aperture_delay_fine;

   localparam [4:0] ST_IDLE = 5'h01;
   localparam [4:0] ST_SETTLE = 5'h02;
   localparam [4:0] ST_CHECK = 5'h04;
   localparam [4:0] ST_NEXT = 5'h08;
   localparam [4:0] ST_DONE = 5'h10;

   // Two-stage synchronisers for the pins
   reg ref_s1_q, ref_s2_q, ref_s3_q;
   reg ph_s1_q, ph_s2_q;
   // Enable comes from host registers on this clock, so no synchroniser
   reg en_q;
   reg [4:0] state_q;
   reg inv_q;
   reg [`SAC_COARSE_W-1:0] coarse_q;
   reg [7:0] settle_q;
   reg found0_q;
   reg [`SAC_COARSE_W-1:0] best0_q;
   reg cal_valid_q;
   reg [7:0] wait_q;
   reg apply_inv_d;
   reg [`SAC_COARSE_W-1:0] apply_coarse_d;
   reg [`SAC_FINE_W-1:0] apply_fine_d;

   wire ref_rise = ref_s2_q & ~ref_s3_q;
   wire en_rise = align_cal_enable & ~en_q;
   // A match means the falling-edge phase sample sees the reference rise
   wire aligned = ref_rise & ph_s2_q;

   assign align_cal_busy = (state_q != ST_IDLE) && (state_q != ST_DONE);

   always @(posedge sys_clk) begin
      if (!reset_n) begin
         ref_s1_q <= 1'b0;
         ref_s2_q <= 1'b0;
         ref_s3_q <= 1'b0;
         ph_s1_q <= 1'b0;
         ph_s2_q <= 1'b0;
         en_q <= 1'b0;
      end else begin
         ref_s1_q <= sysref_in;
         ref_s2_q <= ref_s1_q;
         ref_s3_q <= ref_s2_q;
         ph_s1_q <= clk_fall_phase_in;
         ph_s2_q <= ph_s1_q;
         en_q <= align_cal_enable;
      end
   end

   always @(posedge sys_clk) begin
      if (!reset_n) begin
         state_q <= ST_IDLE;
         inv_q <= 1'b0;
         coarse_q <= 8'h00;
         settle_q <= 8'h00;
         found0_q <= 1'b0;
         best0_q <= 8'h00;
         cal_valid_q <= 1'b0;
         wait_q <= 8'h00;
         align_cal_complete <= 1'b0;
         align_cal_result <= 17'h00000;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (en_rise) begin
                  align_cal_complete <= 1'b0;
                  inv_q <= 1'b0;
                  coarse_q <= 8'h00;
                  found0_q <= 1'b0;
                  // Forget any earlier result until this search ends
                  cal_valid_q <= 1'b0;
                  settle_q <= `SAC_SETTLE_CYCLES;
                  state_q <= ST_SETTLE;
               end
            end
            ST_SETTLE: begin
               // Wait for the new delay to settle before judging it
               if (settle_q == 8'h00) begin
                  wait_q <= `SAC_REF_WAIT_CYCLES;
                  state_q <= ST_CHECK;
               end else begin
                  settle_q <= settle_q - 8'h01;
               end
            end
            ST_CHECK: begin
               if (ref_rise) begin
                  state_q <= ST_NEXT;
                  if (aligned) begin
                     if (!inv_q) begin
                        // Normal polarity found; now try inverted
                        found0_q <= 1'b1;
                        best0_q <= coarse_q;
                        inv_q <= 1'b1;
                        coarse_q <= 8'h00;
                        settle_q <= `SAC_SETTLE_CYCLES;
                        state_q <= ST_SETTLE;
                     end else begin
                        // Inverted found at or below best normal: it wins
                        state_q <= ST_DONE;
                        cal_valid_q <= 1'b1;
                        align_cal_complete <= 1'b1;
                        align_cal_result <= {1'b1, coarse_q, 8'h00};
                     end
                  end
               end else if (wait_q == 8'h00) begin
                  // Reference lost: score the step as a miss rather than hang,
                  // so the search still ends and reports completion
                  state_q <= ST_NEXT;
               end else begin
                  wait_q <= wait_q - 8'h01;
               end
            end
            ST_NEXT: begin
               if ((inv_q && found0_q && coarse_q == best0_q) ||
                   coarse_q == `SAC_COARSE_MAX) begin
                  if (!inv_q) begin
                     inv_q <= 1'b1;
                     coarse_q <= 8'h00;
                     settle_q <= `SAC_SETTLE_CYCLES;
                     state_q <= ST_SETTLE;
                  end else begin
                     // Inverted no better: keep normal result if any
                     state_q <= ST_DONE;
                     cal_valid_q <= found0_q;
                     align_cal_complete <= 1'b1;
                     align_cal_result <= {1'b0, found0_q ? best0_q : 8'h00, 8'h00};
                  end
               end else begin
                  coarse_q <= coarse_q + 8'h01;
                  settle_q <= `SAC_SETTLE_CYCLES;
                  state_q <= ST_SETTLE;
               end
            end
            ST_DONE: begin
               // Result stays applied until the host drops enable
               if (!align_cal_enable) begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Applied delay: search value while busy, a found (valid) result while enabled after,
   // otherwise the manual fields (also how a stored result is restored).
   always @* begin
      apply_inv_d = manual_clock_invert;
      apply_coarse_d = manual_delay_coarse;
      apply_fine_d = manual_delay_fine;
      if (align_cal_busy) begin
         apply_inv_d = inv_q;
         apply_coarse_d = coarse_q;
         apply_fine_d = 8'h00;
      end else if (state_q == ST_DONE && cal_valid_q) begin
         apply_inv_d = align_cal_result[`SAC_RES_INV_BIT];
         apply_coarse_d = align_cal_result[`SAC_RES_COARSE_HI:`SAC_RES_COARSE_LO];
         apply_fine_d = align_cal_result[`SAC_RES_FINE_HI:`SAC_RES_FINE_LO];
      end
   end

   always @(posedge sys_clk) begin
      if (!reset_n) begin
         aperture_clock_invert <= 1'b0;
         aperture_delay_coarse <= 8'h00;
         aperture_delay_fine <= 8'h00;
      end else begin
         aperture_clock_invert <= apply_inv_d;
         aperture_delay_coarse <= apply_coarse_d;
         aperture_delay_fine <= apply_fine_d;
      end
   end
endmodule

// ---- sim/sac_ref_source.sv ----
`timescale 1ns/1ps
module sac_ref_source #(
   parameter int PERIOD = 16
) (
   input wire logic sys_clk,
   input wire logic clock_invert,
   input wire logic [7:0] delay_coarse,
   output logic sysref,
   output logic phase_aligned
);
   int cnt = 0;
   // Free-running reference, never a lone pulse or a gapped train
   always @(negedge sys_clk) begin
      cnt <= (cnt + 1) % PERIOD;
   end
   assign sysref = cnt < PERIOD / 2;
   // Inverted aligns at a smaller coarse step, so it must be chosen
   assign phase_aligned = delay_coarse == (clock_invert ? 8'h03 : 8'h05);
endmodule

// ---- sim/sac_align_cal_assertions.sv ----
`timescale 1ns/1ps
`include "sac_regs.vh"
module sac_align_chk (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic align_cal_enable,
   input wire logic manual_clock_invert,
   input wire logic [`SAC_COARSE_W-1:0] manual_delay_coarse,
   input wire logic [`SAC_FINE_W-1:0] manual_delay_fine,
   input wire logic align_cal_complete,
   input wire logic align_cal_busy,
   input wire logic [`SAC_RESULT_W-1:0] align_cal_result,
   input wire logic aperture_clock_invert,
   input wire logic [`SAC_COARSE_W-1:0] aperture_delay_coarse,
   input wire logic [`SAC_FINE_W-1:0] aperture_delay_fine
);
   wire [16:0] applied = {aperture_clock_invert, aperture_delay_coarse, aperture_delay_fine};
   wire [16:0] manual = {manual_clock_invert, manual_delay_coarse, manual_delay_fine};
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   property p_start; $rose(align_cal_enable) && !align_cal_busy |=> align_cal_busy; endproperty
   a_start: assert property (p_start) else $error("search did not start");
   property p_clear; $rose(align_cal_enable) && !align_cal_busy |=> !align_cal_complete; endproperty
   a_clear: assert property (p_clear) else $error("complete not cleared");
   property p_excl; align_cal_busy |-> !align_cal_complete; endproperty
   a_excl: assert property (p_excl) else $error("complete high while busy");
   property p_done; $fell(align_cal_busy) |-> align_cal_complete; endproperty
   a_done: assert property (p_done) else $error("search ended without complete");
   property p_hold;
      align_cal_complete && !$rose(align_cal_enable) |=> $stable(align_cal_result);
   endproperty
   a_hold: assert property (p_hold) else $error("result changed");
   property p_apply;
      align_cal_complete && align_cal_enable && !$rose(align_cal_enable) &&
         align_cal_result != 0 |=> applied == $past(align_cal_result);
   endproperty
   a_apply: assert property (p_apply) else $error("result not applied");
   property p_manual;
      (!align_cal_enable && !align_cal_busy && $stable(manual)) [*2] |=> applied == $past(manual);
   endproperty
   a_manual: assert property (p_manual) else $error("manual not applied");
   property p_pol;
      $rose(align_cal_busy) |-> ##[1:10] (!aperture_clock_invert && aperture_delay_coarse == 0);
   endproperty
   a_pol: assert property (p_pol) else $error("search not from normal zero");
   c_start: cover property ($rose(align_cal_busy));
   c_done: cover property ($rose(align_cal_complete));
   c_inv: cover property (align_cal_complete && align_cal_result[16]);
endmodule
bind sac_align_cal sac_align_chk u_chk (
   .sys_clk(sys_clk),
   .reset_n(reset_n),
   .align_cal_enable(align_cal_enable),
   .manual_clock_invert(manual_clock_invert),
   .manual_delay_coarse(manual_delay_coarse),
   .manual_delay_fine(manual_delay_fine),
   .align_cal_complete(align_cal_complete),
   .align_cal_busy(align_cal_busy),
   .align_cal_result(align_cal_result),
   .aperture_clock_invert(aperture_clock_invert),
   .aperture_delay_coarse(aperture_delay_coarse),
   .aperture_delay_fine(aperture_delay_fine)
);

// ---- sim/sac_align_cal_test.sv ----
`timescale 1ns/1ps
`include "sac_regs.vh"
module sac_align_cal_test;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic align_cal_enable = 1'b0;
   logic [`SAC_CFG_W-1:0] align_cal_config = 8'h00;
   logic manual_clock_invert = 1'b1;
   logic [`SAC_COARSE_W-1:0] manual_delay_coarse = 8'h2A;
   logic [`SAC_FINE_W-1:0] manual_delay_fine = 8'h07;
   wire sysref_in, clk_fall_phase_in, align_cal_complete, align_cal_busy, aperture_clock_invert;
   wire [`SAC_RESULT_W-1:0] align_cal_result;
   wire [`SAC_COARSE_W-1:0] aperture_delay_coarse;
   wire [`SAC_FINE_W-1:0] aperture_delay_fine;
   wire [16:0] applied = {aperture_clock_invert, aperture_delay_coarse, aperture_delay_fine};
   int n_mismatch = 0;
   int compares = 0;
   always #25 sys_clk = ~sys_clk;
   sac_align_cal uut (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .sysref_in(sysref_in),
      .clk_fall_phase_in(clk_fall_phase_in),
      .align_cal_enable(align_cal_enable),
      .align_cal_config(align_cal_config),
      .manual_clock_invert(manual_clock_invert),
      .manual_delay_coarse(manual_delay_coarse),
      .manual_delay_fine(manual_delay_fine),
      .align_cal_complete(align_cal_complete),
      .align_cal_busy(align_cal_busy),
      .align_cal_result(align_cal_result),
      .aperture_clock_invert(aperture_clock_invert),
      .aperture_delay_coarse(aperture_delay_coarse),
      .aperture_delay_fine(aperture_delay_fine)
   );
   sac_ref_source ref_src (.sys_clk(sys_clk), .clock_invert(aperture_clock_invert),
      .delay_coarse(aperture_delay_coarse), .sysref(sysref_in), .phase_aligned(clk_fall_phase_in));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic final_report;
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic t_reset_stored;
      repeat (3) @(negedge sys_clk);
      check("applied in reset", applied, 17'h00000);
      reset_n = 1'b1;
      repeat (3) @(negedge sys_clk);
      check("stored applied", applied, 17'h12A07);
   endtask
   task automatic t_auto;
      // No converter calibration runs around this search
      // Reference sampling position is left at zero
      align_cal_config = 8'h00;
      @(negedge sys_clk);
      align_cal_enable = 1'b1;
      @(negedge sys_clk);
      check("busy", align_cal_busy, 1'b1);
      check("complete early", align_cal_complete, 1'b0);
      for (int i = 0; i < 30000 && align_cal_complete !== 1'b1; i++) @(negedge sys_clk);
      check("complete", align_cal_complete, 1'b1);
      check("result", align_cal_result, 17'h10300);
      @(negedge sys_clk);
      check("applied result", applied, 17'h10300);
   endtask
   task automatic t_manual_restart;
      {manual_clock_invert, manual_delay_coarse, manual_delay_fine} = 17'h08011;
      align_cal_enable = 1'b0;
      repeat (3) @(negedge sys_clk);
      check("manual applied", applied, 17'h08011);
      check("complete stands", align_cal_complete, 1'b1);
      align_cal_enable = 1'b1;
      repeat (2) @(negedge sys_clk);
      check("complete cleared", align_cal_complete, 1'b0);
      reset_n = 1'b0;
      align_cal_enable = 1'b0;
      repeat (3) @(negedge sys_clk);
      check("busy after reset", align_cal_busy, 1'b0);
      reset_n = 1'b1;
      repeat (3) @(negedge sys_clk);
      check("complete after reset", align_cal_complete, 1'b0);
      check("result after reset", align_cal_result, 17'h00000);
      check("manual after reset", applied, 17'h08011);
   endtask
   initial begin
      repeat (60000) @(posedge sys_clk);
      n_mismatch++;
      final_report;
   end
   initial begin
      t_reset_stored;
      t_auto;
      t_manual_restart;
      final_report;
   end
endmodule
